// [verilog/scs_consts.vh]
// constants for the system clock and standby control block
`ifndef SCS_CONSTS_VH
`define SCS_CONSTS_VH

// register byte address on the apb bus
`define SCS_CTRL_ADDR 8'hF0
`define SCS_CTRL_RESET 8'h04
// writable bits of the control register; the unused bit reads as one
`define SCS_CTRL_WMASK 8'hFB
`define SCS_CTRL_RMASK_SET 8'h04

// field positions
`define SCS_SOFTWARE_STANDBY_SELECT_BIT 7
`define SCS_STS_HI 6
`define SCS_STS_LO 4
`define SCS_LOW_SPEED_CLOCK_SELECT_BIT 3
`define SCS_MA_HI 1
`define SCS_MA_LO 0

// medium speed divider terminal counts (divide by n, count 0..n-1)
`define SCS_DIV16_LAST 7'h0F
`define SCS_DIV32_LAST 7'h1F
`define SCS_DIV64_LAST 7'h3F
`define SCS_DIV128_LAST 7'h7F

// settling waits in states (one state is one system clock cycle)
`define SCS_WAIT_0 8192
`define SCS_WAIT_1 16384
`define SCS_WAIT_2 32768
`define SCS_WAIT_3 65536
`define SCS_WAIT_4 131072
`define SCS_WAIT_5 18'h00002
`define SCS_WAIT_6 18'h00008
`define SCS_WAIT_7 18'h00010
`define SCS_WAIT_W 18

`endif

// [verilog/scs_wait_timer.v]
// settling wait counter started on wake-up, reports when the wait has elapsed
`timescale 1ns/1ns
module scs_wait_timer (
   clk_sys,
   sys_rst,
   clk_en,
   start,
   length,
   busy,
   done
);
   input wire clk_sys; // system clock
   input wire sys_rst; // synchronous reset, active high
   input wire clk_en; // freezes the counter while low
   input wire start; // one-cycle pulse, loads the wait length
   input wire [17:0] length; // wait in states, at least one
   output reg busy; // high while the wait runs
   output reg done; // one-cycle pulse when the wait ends

   reg [17:0] count_reg;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         count_reg <= 18'h00000;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         if (start) begin
            count_reg <= length - 18'h00001;
            busy <= 1'b1;
         end else if (busy) begin
            if (count_reg == 18'h00000) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               count_reg <= count_reg - 18'h00001;
            end
         end
      end
   end
endmodule

// [verilog/scs_top.v]
// system clock select, medium speed divider and standby control with apb access
//
// Summary of operation
// - control register at byte address F0, fields standby, wait, low speed, divider.
// - medium speed clock is oscillator divided by 16, 32, 64 or 128.
// - low speed bit 0 runs cpu on system clock, 1 on subclock.
// - wait codes 000 to 100 give 8192 up to 131072 states.
// - wait codes 101, 110, 111 give 2, 8 and 16 states.
// - sleep request enters sleep if standby bit 0, else standby or watch.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "scs_consts.vh"
module scs_top (
   clk_sys,
   sys_rst,
   clk_en,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   sleep_req,
   watch_enable,
   medium_speed_on,
   wake_event,
   subclock_in,
   cpu_clk_en,
   medium_clk_tick,
   cpu_on_subclock,
   cpu_run,
   sleep_mode,
   standby_mode,
   watch_mode,
   osc_stop
);
   parameter WAIT_0 = `SCS_WAIT_0;
   parameter WAIT_1 = `SCS_WAIT_1;
   parameter WAIT_2 = `SCS_WAIT_2;
   parameter WAIT_3 = `SCS_WAIT_3;
   parameter WAIT_4 = `SCS_WAIT_4;

   input wire clk_sys; // oscillator clock, 250 MHz
   input wire sys_rst; // synchronous reset, active high
   input wire clk_en; // freezes all state while low
   input wire psel; // apb select
   input wire penable; // apb access phase
   input wire pwrite; // apb direction, high for write
   input wire [7:0] paddr; // apb byte address
   input wire [31:0] pwdata; // apb write data
   output reg [31:0] prdata; // apb read data
   output reg pready; // apb transfer done
   output reg pslverr; // apb error for unmapped address
   input wire sleep_req; // one-cycle sleep instruction pulse from cpu
   input wire watch_enable; // watch timer running, picks watch over standby
   input wire medium_speed_on; // cpu uses the medium speed clock in active mode
   input wire wake_event; // wake-up request from pins, asynchronous
   input wire subclock_in; // subclock, asynchronous, much slower than clk_sys
   output reg cpu_clk_en; // cpu clock enable pulse or level
   output reg medium_clk_tick; // one pulse per medium speed period
   output reg cpu_on_subclock; // cpu follows the subclock
   output reg cpu_run; // cpu released
   output reg sleep_mode; // in sleep mode
   output reg standby_mode; // in standby mode
   output reg watch_mode; // in watch mode
   output reg osc_stop; // request to stop the oscillator

   localparam ST_ACTIVE = 3'b000;
   localparam ST_SLEEP = 3'b001;
   localparam ST_STANDBY = 3'b010;
   localparam ST_WATCH = 3'b011;
   localparam ST_SETTLE = 3'b100;

   reg [7:0] ctrl_reg;
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [6:0] div_cnt_reg;
   reg [6:0] div_last;
   reg sub_prev_reg;
   reg timer_start_reg;
   reg [17:0] wait_len;
   wire [1:0] pin_async;
   wire [1:0] pin_sync;
   wire wake_sync;
   wire sub_sync;
   wire timer_done;
   wire sub_rise;
   wire sel_ok;
   wire bus_done;
   wire bus_write;
   wire [7:0] ctrl_read;

   // apb decode; a transfer finishes on the second access cycle
   assign sel_ok = (paddr == `SCS_CTRL_ADDR);
   assign bus_done = psel & penable & pready;
   assign bus_write = bus_done & pwrite & sel_ok;
   assign ctrl_read = (ctrl_reg & `SCS_CTRL_WMASK) | `SCS_CTRL_RMASK_SET;
   assign sub_rise = sub_sync & ~sub_prev_reg;
   assign wake_sync = pin_sync[0];
   assign sub_sync = pin_sync[1];

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_reg <= `SCS_CTRL_RESET;
      end else if (clk_en) begin
         if (bus_write) begin
            ctrl_reg <= pwdata[7:0] & `SCS_CTRL_WMASK;
         end
      end
   end

   // apb answer, one wait state; pready drops right after each completion
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (clk_en) begin
         if (psel & penable & ~pready) begin
            pready <= 1'b1;
            pslverr <= ~sel_ok;
            if (~pwrite & sel_ok) begin
               prdata <= {24'h000000, ctrl_read};
            end else begin
               prdata <= 32'h00000000;
            end
         end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // pins come from other domains: two flops before anything reads them
   // index 0 carries the wake pin, index 1 the subclock
   assign pin_async = {subclock_in, wake_event};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         reg meta_reg;
         reg sync_reg;
         always @(posedge clk_sys) begin
            if (sys_rst) begin
               meta_reg <= 1'b0;
               sync_reg <= 1'b0;
            end else if (clk_en) begin
               meta_reg <= pin_async[gi];
               sync_reg <= meta_reg;
            end
         end
         assign pin_sync[gi] = sync_reg;
      end
   endgenerate

   // previous synced subclock level, for the rising edge detector
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sub_prev_reg <= 1'b0;
      end else if (clk_en) begin
         sub_prev_reg <= sub_sync;
      end
   end

   // terminal count per divider code, ascending
   always @* begin
      case (ctrl_reg[`SCS_MA_HI:`SCS_MA_LO])
         2'b00: div_last = `SCS_DIV16_LAST;
         2'b01: div_last = `SCS_DIV32_LAST;
         2'b10: div_last = `SCS_DIV64_LAST;
         2'b11: div_last = `SCS_DIV128_LAST;
         default: div_last = `SCS_DIV16_LAST;
      endcase
   end

   // free-running divider; a code change applies to the running period at once
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         div_cnt_reg <= 7'h00;
         medium_clk_tick <= 1'b0;
      end else if (clk_en) begin
         if (div_cnt_reg >= div_last) begin
            div_cnt_reg <= 7'h00;
            medium_clk_tick <= 1'b1;
         end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
            medium_clk_tick <= 1'b0;
         end
      end
   end

   // long waits, parameters so a simulation can shorten them
   // short waits for an external or already stable clock
   always @* begin
      case (ctrl_reg[`SCS_STS_HI:`SCS_STS_LO])
         3'b000: wait_len = WAIT_0[17:0];
         3'b001: wait_len = WAIT_1[17:0];
         3'b010: wait_len = WAIT_2[17:0];
         3'b011: wait_len = WAIT_3[17:0];
         3'b100: wait_len = WAIT_4[17:0];
         3'b101: wait_len = `SCS_WAIT_5;
         3'b110: wait_len = `SCS_WAIT_6;
         3'b111: wait_len = `SCS_WAIT_7;
         default: wait_len = `SCS_WAIT_5;
      endcase
   end

   // power mode sequencing
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_ACTIVE: begin
            // standby bit picks sleep or standby/watch
            if (sleep_req) begin
               if (~ctrl_reg[`SCS_SOFTWARE_STANDBY_SELECT_BIT]) begin
                  state_next = ST_SLEEP;
               end else if (watch_enable) begin
                  state_next = ST_WATCH;
               end else begin
                  state_next = ST_STANDBY;
               end
            end
         end
         ST_SLEEP: begin
            // oscillator keeps running in sleep, so no settling is needed
            if (wake_sync) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_STANDBY, ST_WATCH: begin
            // the oscillator restarts on leaving, so settle before the cpu runs
            if (wake_sync) begin
               state_next = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // release only after the selected wait
            if (timer_done) begin
               state_next = ST_ACTIVE;
            end
         end
         default: begin
            state_next = ST_ACTIVE;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         state_reg <= ST_ACTIVE;
         timer_start_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         // start the settling count on wake from standby or watch
         timer_start_reg <= (state_next == ST_SETTLE) & (state_reg != ST_SETTLE);
      end
   end

   scs_wait_timer u_wait (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .start(timer_start_reg),
      .length(wait_len),
      .busy(),
      .done(timer_done)
   );

   // mode outputs and cpu clock selection, all registered
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         cpu_run <= 1'b1;
         sleep_mode <= 1'b0;
         standby_mode <= 1'b0;
         watch_mode <= 1'b0;
         osc_stop <= 1'b0;
         cpu_on_subclock <= 1'b0;
         cpu_clk_en <= 1'b0;
      end else if (clk_en) begin
         cpu_run <= (state_next == ST_ACTIVE);
         sleep_mode <= (state_next == ST_SLEEP);
         standby_mode <= (state_next == ST_STANDBY);
         watch_mode <= (state_next == ST_WATCH);
         // the oscillator restarts as settling begins; the wait covers
         // its start-up, not the few cycles of wake synchronisation
         osc_stop <= (state_next == ST_STANDBY) | (state_next == ST_WATCH);
         // low speed bit picks subclock or system clock
         cpu_on_subclock <= ctrl_reg[`SCS_LOW_SPEED_CLOCK_SELECT_BIT];
         if (state_next != ST_ACTIVE) begin
            cpu_clk_en <= 1'b0;
         end else if (ctrl_reg[`SCS_LOW_SPEED_CLOCK_SELECT_BIT]) begin
            cpu_clk_en <= sub_rise;
         end else if (medium_speed_on) begin
            cpu_clk_en <= medium_clk_tick;
         end else begin
            cpu_clk_en <= 1'b1;
         end
      end
   end
endmodule

// [tb/scs_top_sva.sv]
// port assertions for the clock and standby control block
`timescale 1ns/1ns
module scs_top_sva (
   input wire clk_sys, // clock
   input wire sys_rst, // reset
   input wire pwrite, // apb direction
   input wire [7:0] paddr, // apb address
   input wire [31:0] prdata, // apb read data
   input wire pready, // apb done
   input wire pslverr, // apb error
   input wire sleep_req, // sleep pulse
   input wire watch_enable, // watch select
   input wire cpu_clk_en, // cpu clock enable
   input wire medium_clk_tick, // medium tick
   input wire cpu_on_subclock, // subclock select
   input wire cpu_run, // cpu released
   input wire sleep_mode, // sleep
   input wire standby_mode, // standby
   input wire watch_mode, // watch
   input wire osc_stop // oscillator stop
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // applying a reset also drops the oscillator stop, so it is excluded
   sequence s_wake;
      $fell(osc_stop) && !$past(sys_rst);
   endsequence
   sequence s_held;
      !cpu_run [*3];
   endsequence
   property p_rdy; pready |=> !pready; endproperty
   property p_err; pready |-> pslverr == (paddr != 8'hF0); endproperty
   property p_rd; pready && !pwrite && paddr == 8'hF0 |-> prdata[31:8] == 24'h0 && prdata[2];
   endproperty
   property p_low_speed_clock_select; $changed(cpu_on_subclock) |-> $past(pready && pwrite, 2) ||
      $past(pready && pwrite, 3) || $past(sys_rst) || $past(sys_rst, 2); endproperty
   property p_clk; !cpu_run && $past(!cpu_run) |-> !cpu_clk_en; endproperty
   property p_tick; medium_clk_tick |=> !medium_clk_tick [*8]; endproperty
   property p_sleep; sleep_req && cpu_run |=> !cpu_run &&
      (sleep_mode || standby_mode || watch_mode); endproperty
   property p_osc; osc_stop == (standby_mode || watch_mode); endproperty
   property p_watch; sleep_req && cpu_run && watch_enable |=> !standby_mode; endproperty
   property p_settle; s_wake |-> s_held; endproperty
   a_rdy: assert property (p_rdy) else $error("pready too long");
   a_err: assert property (p_err) else $error("bad pslverr");
   a_rd: assert property (p_rd) else $error("bad read data");
   a_low_speed_clock_select: assert property (p_low_speed_clock_select) else $error("select moved alone");
   a_clk: assert property (p_clk) else $error("cpu clocked off");
   a_tick: assert property (p_tick) else $error("tick too soon");
   a_sleep: assert property (p_sleep) else $error("no mode entry");
   a_osc: assert property (p_osc) else $error("bad osc stop");
   a_watch: assert property (p_watch) else $error("standby in watch");
   a_settle: assert property (p_settle) else $error("released early");
endmodule
bind scs_top scs_top_sva i_sva (.clk_sys, .sys_rst, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .sleep_req, .watch_enable, .cpu_clk_en, .medium_clk_tick, .cpu_on_subclock,
   .cpu_run, .sleep_mode, .standby_mode, .watch_mode, .osc_stop);

// [tb/tb_scs_top.sv]
// testbench for the clock and standby control block
`timescale 1ns/1ns
module tb_scs_top;
   logic clk_sys, sys_rst, clk_en, psel, penable, pwrite, sleep_req, watch_enable, wake_event;
   logic medium_speed_on, subclock_in, pready, pslverr, cpu_clk_en, medium_clk_tick, e;
   logic cpu_on_subclock, cpu_run, sleep_mode, standby_mode, watch_mode, osc_stop;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   int n_fail = 0, num_checks = 0, cyc = 0, k;
   // short waits stand in for the long settling counts
   int wl[8] = '{20, 24, 28, 32, 36, 2, 8, 16};
   scs_top #(.WAIT_0(20), .WAIT_1(24), .WAIT_2(28), .WAIT_3(32), .WAIT_4(36)) i_dut (
      .clk_sys, .sys_rst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .sleep_req, .watch_enable, .medium_speed_on, .wake_event, .subclock_in,
      .cpu_clk_en, .medium_clk_tick, .cpu_on_subclock, .cpu_run, .sleep_mode, .standby_mode,
      .watch_mode, .osc_stop);
   initial begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task complete_run;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'h1);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task do_reset;
      sys_rst <= 1'h1;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'h0;
   endtask
   task cnt(input int c);
      repeat (c) begin
         @(posedge clk_sys);
         k += cpu_clk_en;
      end
   endtask
   task t_regs;
      apb(1'h0, 8'hF0, 32'h0);
      chk(q, 32'h04, "reset value");
      apb(1'h1, 8'hF0, 32'hFFFFFF80);
      apb(1'h0, 8'hF0, 32'h0);
      chk(q, 32'h84, "upper bits dropped");
      apb(1'h1, 8'hF0, 32'h7B);
      apb(1'h0, 8'hF0, 32'h0);
      chk(q, 32'h7F, "all fields");
      chk(e, 1'h0, "no error on mapped read");
      apb(1'h1, 8'hF4, 32'hFF);
      chk(e, 1'h1, "unmapped write");
      apb(1'h0, 8'hF4, 32'h0);
      chk(e, 1'h1, "unmapped read error");
      chk(q, 32'h0, "unmapped read data");
      apb(1'h0, 8'hF0, 32'h0);
      chk(q, 32'h7F, "unmapped write ignored");
      $display("test regs done");
   endtask
   task t_low_speed_clock_select;
      apb(1'h0, 8'hF0, 32'h0);
      chk(q, 32'h04, "reset value after second reset");
      apb(1'h1, 8'hF0, 32'h08);
      repeat (3) @(posedge clk_sys);
      chk(cpu_on_subclock, 1'h1, "subclock selected");
      k = 0;
      repeat (4) begin
         subclock_in <= 1'h1;
         cnt(10);
         subclock_in <= 1'h0;
         cnt(10);
      end
      chk(k, 4, "one enable per subclock rise");
      apb(1'h1, 8'hF0, 32'h00);
      repeat (3) @(posedge clk_sys);
      chk(cpu_on_subclock, 1'h0, "system clock selected");
      k = 0;
      cnt(10);
      chk(k, 10, "cpu clock runs");
      $display("test low_speed_clock_select done");
   endtask
   task go_sleep;
      @(posedge clk_sys);
      sleep_req <= 1'h1;
      @(posedge clk_sys);
      sleep_req <= 1'h0;
      @(posedge clk_sys);
   endtask
   task wake(output int m);
      int n;
      n = 0;
      m = 0;
      wake_event <= 1'h1;
      while (osc_stop !== 1'h0 && n < 50) begin
         @(posedge clk_sys);
         n++;
      end
      while (cpu_run !== 1'h1 && m < 300) begin
         @(posedge clk_sys);
         m++;
      end
      wake_event <= 1'h0;
   endtask
   task t_standby;
      int i, m, off;
      for (i = 0; i < 8; i++) begin
         apb(1'h1, 8'hF0, 32'h80 | (i << 4));
         go_sleep();
         chk({standby_mode, osc_stop, cpu_run}, 3'h6, "standby entered");
         wake(m);
         if (i == 0) off = m - wl[0];
         chk(m - wl[i], off, "settling wait per code");
      end
      chk(off > 0 && off < 8, 1'h1, "wait before release");
      $display("test standby done");
   endtask
   task t_watch_sleep;
      int m;
      watch_enable <= 1'h1;
      apb(1'h1, 8'hF0, 32'hD0);
      go_sleep();
      chk({watch_mode, standby_mode, osc_stop}, 3'h5, "watch entered");
      wake(m);
      apb(1'h1, 8'hF0, 32'h50);
      go_sleep();
      chk({sleep_mode, osc_stop, cpu_run}, 3'h4, "sleep entered");
      wake(m);
      chk(m < 8, 1'h1, "sleep wakes at once");
      watch_enable <= 1'h0;
      $display("test watch sleep done");
   endtask
   task tick(output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         k += cpu_clk_en;
      end while (medium_clk_tick !== 1'h1 && n < 300);
   endtask
   task t_div;
      int i, n;
      medium_speed_on <= 1'h1;
      // ascending codes only, a shorter count would cut the running period
      for (i = 0; i < 4; i++) begin
         apb(1'h1, 8'hF0, i);
         tick(n);
         tick(n);
         k = 0;
         tick(n);
         chk(n, 16 << i, "divider period");
         chk(k, 1, "cpu follows medium tick");
      end
      $display("test divider done");
   endtask
   initial begin
      {psel, penable, pwrite, sleep_req, watch_enable, wake_event} = 6'h0;
      {medium_speed_on, subclock_in} = 2'h0;
      clk_en = 1'h1;
      sys_rst = 1'h1;
      paddr = 8'hF0;
      pwdata = 32'h0;
      do_reset();
      t_regs();
      do_reset();
      t_low_speed_clock_select();
      t_standby();
      t_watch_sleep();
      t_div();
      complete_run();
   end
endmodule
